// File: hw/pcq_regs.svh
// pcq_regs.svh: offsets, field positions and reset values of the queue
// assumes byte addressing on a 32-bit avalon-mm slave, one word per register
`ifndef PCQ_REGS_SVH
`define PCQ_REGS_SVH

`define PCQ_ADDR_W        5
`define PCQ_OFS_CTRL      5'h00
`define PCQ_OFS_PUSH      5'h04
`define PCQ_OFS_OFFSET    5'h08
`define PCQ_OFS_LEVEL     5'h0C
`define PCQ_OFS_CAPACITY  5'h10
`define PCQ_OFS_STATUS    5'h14
`define PCQ_OFS_OLDEST    5'h18
`define PCQ_OFS_TRIGGER   5'h1C

`define PCQ_CTRL_EN       0
`define PCQ_CTRL_SRC_LO   1
`define PCQ_CTRL_SRC_HI   2
`define PCQ_CTRL_FLUSH    8
`define PCQ_CTRL_POP      9

`define PCQ_ST_EMPTY      0
`define PCQ_ST_HIGH       1
`define PCQ_ST_OVERRUN    2
`define PCQ_ST_MATCH      3
`define PCQ_ST_COUNT      8

`define PCQ_CTRL_RST      3'h0
`define PCQ_OFFSET_RST    32'h0000_0000

`endif

// File: hw/pcq_pkg.sv
// pcq_pkg: types shared by the position compare queue
// assumes pcq_regs.svh for all numeric constants
package pcq_pkg;

  // which position signal the comparator watches
  typedef enum logic [1:0] {
    PCQ_SRC_FEEDBACK = 2'b00,
    PCQ_SRC_MASTER   = 2'b01,
    PCQ_SRC_COMMAND  = 2'b10
  } pcq_src_t;

  typedef struct packed {
    pcq_src_t src;
    logic     comparator_enable;
  } pcq_ctrl_t;

  typedef struct packed {
    logic match_event;
    logic overrun_flag;
    logic high_water_flag;
    logic fifo_empty_flag;
  } pcq_flags_t;

endpackage : pcq_pkg

// File: hw/pcq_top.sv
// pcq_top: position queue with exit-position comparator, avalon-mm slave
// assumes position inputs come from logic on mclk; no synchroniser on them
// assumes software flushes before use; reset alone also empties the queue
//
// Contract
// - hold no more than configured capacity
// - refuse pushes while overrun flag active
// - overrun flag means no room left
// - oldest entry out; trigger is oldest+offset
// - high-water flag while count at/above level
// - high-water flag is informational, not a fault
// - flush discards all stored entries
// - comparator disabled means no match event
// - empty flag while queue holds nothing
// - match on equality, cleared by pop
// - trigger refreshed only on first push, pop, flush
// - pop removes oldest, keeps arrival order
// - source select picks comparison position
`timescale 1ns/10ps
`include "pcq_regs.svh"

module pcq_top
  import pcq_pkg::*;
#(
  parameter int DEPTH = 16,
  parameter int DW    = 32
) (
  input  wire logic                   mclk,
  input  wire logic                   rst,
  input  wire logic [`PCQ_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic [DW-1:0]          pos_feedback,
  input  wire logic [DW-1:0]          pos_master,
  input  wire logic [DW-1:0]          pos_command,
  output logic                        match_event,
  output logic                        fifo_empty_flag,
  output logic                        high_water_flag,
  output logic                        overrun_flag,
  output logic      [DW-1:0]          oldest_entry,
  output logic      [DW-1:0]          trigger_position
);

  // pointers wrap explicitly, so the depth need not be a power of two;
  // the count is one bit wider than the pointers so a full queue and an
  // empty one never share a code
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = PW + 1;
  localparam logic [CW-1:0] CAP_MAX = CW'(DEPTH);

  // storage and queue state
  logic [DW-1:0]   mem_ff [DEPTH];
  logic [PW-1:0]   rd_ptr_ff, nxt_rd_ptr;
  logic [PW-1:0]   wr_ptr_ff, nxt_wr_ptr;
  logic [CW-1:0]   count_ff, nxt_count;
  logic [DW-1:0]   oldest_ff, nxt_oldest;
  logic [DW-1:0]   trig_ff, nxt_trig;
  pcq_flags_t      flags_ff, nxt_flags;

  // software settings
  pcq_ctrl_t       ctrl_ff, nxt_ctrl;
  logic [DW-1:0]   offset_ff, nxt_offset;
  logic [CW-1:0]   level_ff, nxt_level;
  logic [CW-1:0]   cap_ff, nxt_cap;

  // bus slave state
  logic            ack_ff, nxt_ack;
  logic [31:0]     rdata_ff, nxt_rdata;

  logic            access;
  logic            wr_fire;
  logic [31:0]     wmask;
  logic [31:0]     wdata_m;
  logic            push_fire;
  logic            pop_fire;
  logic            flush_fire;
  logic [DW-1:0]   sel_pos;
  logic [DW-1:0]   push_value;
  logic [PW-1:0]   rd_ptr_inc;
  logic            hit;

  // byte-enable mask; unselected lanes keep the old value in the offset register and are zeroed for push, level and capacity
  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
  end

  // one wait cycle per access: read data is latched in the first cycle,
  // the write lands at the edge where waitrequest is seen low
  // a request held past the low waitrequest is taken as a new access,
  // so its write would be applied a second time
  assign access          = avs_read | avs_write;
  assign avs_waitrequest = access & ~ack_ff;
  assign wr_fire         = avs_write & ack_ff;
  assign avs_readdata    = rdata_ff;

  assign wdata_m    = avs_writedata & wmask;
  assign push_value = DW'(wdata_m);

  // command strobes decoded from register writes
  // pop on an empty queue and push while overrun are dropped silently;
  // software sees either case in the status word
  assign flush_fire = wr_fire && avs_address == `PCQ_OFS_CTRL
                      && avs_writedata[`PCQ_CTRL_FLUSH] && avs_byteenable[1];
  assign pop_fire   = wr_fire && avs_address == `PCQ_OFS_CTRL
                      && avs_writedata[`PCQ_CTRL_POP] && avs_byteenable[1]
                      && !flags_ff.fifo_empty_flag;
  assign push_fire  = wr_fire && avs_address == `PCQ_OFS_PUSH
                      && !flags_ff.overrun_flag;

  // comparison source; the unused code falls back to feedback
  // switching source while armed can match on the new source at once
  always_comb begin
    unique case (ctrl_ff.src)
      PCQ_SRC_FEEDBACK: sel_pos = pos_feedback;
      PCQ_SRC_MASTER:   sel_pos = pos_master;
      PCQ_SRC_COMMAND:  sel_pos = pos_command;
      default:          sel_pos = pos_feedback;
    endcase
  end

  // next read slot, wrapping at the last entry
  assign rd_ptr_inc = (rd_ptr_ff == PW'(DEPTH - 1)) ? '0 : rd_ptr_ff + PW'(1);

  // comparator; gated by enable and by a non-empty queue
  // equality only, against the registered trigger: a source that steps
  // over the target without landing on it never matches, and a match is
  // seen one cycle after the position reaches the target
  assign hit = ctrl_ff.comparator_enable
               && !flags_ff.fifo_empty_flag
               && sel_pos == trig_ff;

  // settings registers
  // level takes the low bits of the word; capacity is clamped so a large
  // value cannot open room that the storage does not have
  always_comb begin
    logic [CW-1:0] cap_w;
    cap_w      = CW'(wdata_m);
    nxt_ctrl   = ctrl_ff;
    nxt_offset = offset_ff;
    nxt_level  = level_ff;
    nxt_cap    = cap_ff;
    if (wr_fire) begin
      unique case (avs_address)
        `PCQ_OFS_CTRL: begin
          if (avs_byteenable[0]) begin
            nxt_ctrl.comparator_enable = avs_writedata[`PCQ_CTRL_EN];
            nxt_ctrl.src = pcq_src_t'(avs_writedata[`PCQ_CTRL_SRC_HI:`PCQ_CTRL_SRC_LO]);
          end
        end
        `PCQ_OFS_OFFSET: begin
          nxt_offset = DW'((offset_ff & ~wmask) | wdata_m);
        end
        `PCQ_OFS_LEVEL: begin
          nxt_level = CW'(wdata_m);
        end
        `PCQ_OFS_CAPACITY: begin
          // capacity can never exceed the physical storage
          nxt_cap = (cap_w > CAP_MAX) ? CAP_MAX : cap_w;
        end
        default: begin
        end
      endcase
    end
  end

  // settings reset to an open queue: level and capacity at full depth
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_ff   <= pcq_ctrl_t'(`PCQ_CTRL_RST);
      offset_ff <= `PCQ_OFFSET_RST;
      level_ff  <= CAP_MAX;
      cap_ff    <= CAP_MAX;
    end else begin
      ctrl_ff   <= nxt_ctrl;
      offset_ff <= nxt_offset;
      level_ff  <= nxt_level;
      cap_ff    <= nxt_cap;
    end
  end

  // queue pointers, oldest entry, trigger position and flags
  // flush beats pop when both bits come in one write; push uses its own
  // register, so it never meets either of them
  always_comb begin
    nxt_rd_ptr  = rd_ptr_ff;
    nxt_wr_ptr  = wr_ptr_ff;
    nxt_count   = count_ff;
    nxt_oldest  = oldest_ff;
    nxt_trig    = trig_ff;
    nxt_flags   = flags_ff;
    if (flush_fire) begin
      // pointers reset, nothing left to read back
      nxt_rd_ptr = '0;
      nxt_wr_ptr = '0;
      nxt_count  = '0;
      nxt_oldest = '0;
      nxt_trig   = '0;
    end else if (pop_fire) begin
      nxt_rd_ptr = rd_ptr_inc;
      nxt_count  = count_ff - CW'(1);
      nxt_oldest = (count_ff > CW'(1)) ? mem_ff[rd_ptr_inc] : '0;
      nxt_trig   = nxt_oldest + offset_ff;
    end else if (push_fire) begin
      nxt_wr_ptr = (wr_ptr_ff == PW'(DEPTH - 1)) ? '0 : wr_ptr_ff + PW'(1);
      nxt_count  = count_ff + CW'(1);
      if (flags_ff.fifo_empty_flag) begin
        nxt_oldest = push_value;
        nxt_trig   = push_value + offset_ff;
      end
    end
    // flags follow the next count, so they change in the same cycle as
    // the pointers they describe
    nxt_flags.fifo_empty_flag = (nxt_count == '0);
    nxt_flags.high_water_flag = (nxt_count >= nxt_level);
    nxt_flags.overrun_flag    = (nxt_count >= nxt_cap);
    // pop or flush consumes the entry that matched, so they beat a new hit
    if (flush_fire || pop_fire || !ctrl_ff.comparator_enable) begin
      nxt_flags.match_event = 1'b0;
    end else if (hit) begin
      nxt_flags.match_event = 1'b1;
    end
  end

  // queue state; reset leaves the queue empty without a flush
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rd_ptr_ff <= '0;
      wr_ptr_ff <= '0;
      count_ff  <= '0;
      oldest_ff <= '0;
      trig_ff   <= '0;
      flags_ff  <= '{match_event: 1'b0, overrun_flag: 1'b0,
                     high_water_flag: 1'b0, fifo_empty_flag: 1'b1};
    end else begin
      rd_ptr_ff <= nxt_rd_ptr;
      wr_ptr_ff <= nxt_wr_ptr;
      count_ff  <= nxt_count;
      oldest_ff <= nxt_oldest;
      trig_ff   <= nxt_trig;
      flags_ff  <= nxt_flags;
    end
  end

  // storage array; no reset, contents are unreachable until written
  // a refused push writes nothing, so an overrun keeps stored entries intact
  always_ff @(posedge mclk) begin
    if (push_fire) begin
      mem_ff[wr_ptr_ff] <= push_value;
    end
  end

  // bus slave: read mux sampled in the wait cycle
  // the read word is frozen in the first cycle of the access; a change
  // during the wait cycle shows up on the next read
  always_comb begin
    nxt_ack   = access & ~ack_ff;
    nxt_rdata = rdata_ff;
    if (avs_read && !ack_ff) begin
      unique case (avs_address)
        `PCQ_OFS_CTRL: begin
          nxt_rdata = 32'({ctrl_ff.src, ctrl_ff.comparator_enable});
        end
        `PCQ_OFS_OFFSET:   nxt_rdata = 32'(offset_ff);
        `PCQ_OFS_LEVEL:    nxt_rdata = 32'(level_ff);
        `PCQ_OFS_CAPACITY: nxt_rdata = 32'(cap_ff);
        `PCQ_OFS_STATUS: begin
          // high-water is a status bit only; nothing is refused for it
          nxt_rdata = (32'(count_ff) << `PCQ_ST_COUNT) | 32'(flags_ff);
        end
        `PCQ_OFS_OLDEST:   nxt_rdata = 32'(oldest_ff);
        `PCQ_OFS_TRIGGER:  nxt_rdata = 32'(trig_ff);
        default:           nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  // bus slave registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // status outputs straight from flops
  // no decode after the flops, so downstream logic sees no glitches
  assign match_event      = flags_ff.match_event;
  assign fifo_empty_flag  = flags_ff.fifo_empty_flag;
  assign high_water_flag  = flags_ff.high_water_flag;
  assign overrun_flag     = flags_ff.overrun_flag;
  assign oldest_entry     = oldest_ff;
  assign trigger_position = trig_ff;

endmodule : pcq_top

// File: test/pcq_pos_src.sv
// pcq_pos_src: stand-in for the three position sources
// assumes the queue's clock; ramps are spaced so one source meets a target
`timescale 1ns/10ps
module pcq_pos_src (
  input  wire logic        mclk,
  input  wire logic        rst,
  output logic      [31:0] pos_feedback,
  output logic      [31:0] pos_master,
  output logic      [31:0] pos_command
);
  logic [31:0] cnt_ff;
  // free ramp, so every target ahead of it is met in bounded time
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) cnt_ff <= 32'h0000_0000;
    else cnt_ff <= cnt_ff + 32'h0000_0001;
  end
  assign pos_feedback = cnt_ff;
  assign pos_master   = cnt_ff + 32'h0000_0100;
  assign pos_command  = cnt_ff + 32'h0000_0200;
endmodule : pcq_pos_src

// File: test/pcq_top_sva.sv
// pcq_sva_chk: queue properties watched at the top ports
// assumes one clock mclk and async active-high rst
`timescale 1ns/10ps
`include "pcq_regs.svh"
module pcq_sva_chk #(
  parameter int DW = 32
) (
  input wire logic                   mclk,
  input wire logic                   rst,
  input wire logic [`PCQ_ADDR_W-1:0] avs_address,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [3:0]             avs_byteenable,
  input wire logic                   avs_waitrequest,
  input wire logic [DW-1:0]          pos_feedback,
  input wire logic [DW-1:0]          pos_master,
  input wire logic [DW-1:0]          pos_command,
  input wire logic                   match_event,
  input wire logic                   fifo_empty_flag,
  input wire logic                   overrun_flag,
  input wire logic [DW-1:0]          oldest_entry,
  input wire logic [DW-1:0]          trigger_position
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  logic wdone, push, ctl, hit_any;
  // completed writes decoded once
  assign wdone = avs_write && !avs_waitrequest;
  assign push = wdone && avs_address == `PCQ_OFS_PUSH && avs_byteenable == 4'hF;
  assign ctl = wdone && avs_address == `PCQ_OFS_CTRL && avs_byteenable[1];
  assign hit_any = trigger_position == pos_feedback || trigger_position == pos_master
    || trigger_position == pos_command;
  sequence s_pop;
    ctl && avs_writedata[`PCQ_CTRL_POP] && !avs_writedata[`PCQ_CTRL_FLUSH];
  endsequence
  empty_nomatch_a: assert property (fifo_empty_flag |-> !match_event)
    else $error("match while empty");
  pop_clears_a: assert property (s_pop |=> !match_event)
    else $error("match kept after pop");
  flush_empties_a: assert property (ctl && avs_writedata[`PCQ_CTRL_FLUSH] |=>
    fifo_empty_flag && !overrun_flag && !match_event && oldest_entry == '0)
    else $error("flush left entries");
  trig_steady_a: assert property (!$stable(trigger_position) |-> $past(wdone))
    else $error("trigger moved without access");
  first_push_a: assert property (push && fifo_empty_flag && !overrun_flag |=>
    !fifo_empty_flag && oldest_entry == $past(avs_writedata))
    else $error("first push not at head");
  push_refused_a: assert property (push && overrun_flag |=> $stable(oldest_entry) && overrun_flag)
    else $error("push taken while overrun");
  match_cause_a: assert property ($rose(match_event) |-> $past(hit_any))
    else $error("match without equality");
  oldest_hold_a: assert property (!$stable(oldest_entry) |-> $past(wdone))
    else $error("head moved without access");
endmodule : pcq_sva_chk

bind pcq_top pcq_sva_chk #(.DW(DW)) u_sva (.mclk(mclk), .rst(rst), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .pos_feedback(pos_feedback), .pos_master(pos_master),
  .pos_command(pos_command), .match_event(match_event), .fifo_empty_flag(fifo_empty_flag),
  .overrun_flag(overrun_flag), .oldest_entry(oldest_entry), .trigger_position(trigger_position));

// File: test/tb_position_compare_queue.sv
// tb_position_compare_queue: register-level tests of the position queue
// assumes pcq_top as avalon slave and pcq_pos_src ramps on its position inputs
`timescale 1ns/10ps
`include "pcq_regs.svh"
module tb_position_compare_queue;
  logic        mclk, rst, avs_read, avs_write, wq, mt, em, hw, ov;
  logic [4:0]  avs_address;
  logic [31:0] wd, rdata, rd, v, old, trg, pf, pm, pc;
  logic [31:0] pos [3];
  int          n_fail, compares, i, k;
  assign pos[0] = pf;
  assign pos[1] = pm;
  assign pos[2] = pc;
  pcq_top #(.DEPTH(16), .DW(32)) uut (.mclk(mclk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(wd), .avs_byteenable(4'hF),
    .avs_readdata(rdata), .avs_waitrequest(wq), .pos_feedback(pf), .pos_master(pm),
    .pos_command(pc), .match_event(mt), .fifo_empty_flag(em), .high_water_flag(hw),
    .overrun_flag(ov), .oldest_entry(old), .trigger_position(trg));
  pcq_pos_src u_src (.mclk(mclk), .rst(rst), .pos_feedback(pf), .pos_master(pm),
    .pos_command(pc));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  // one avalon access; held until waitrequest is seen low, bounded
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    int t = 0;
    @(posedge mclk);
    avs_address <= a;
    wd <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      t++;
    end while (wq !== 1'b0 && t < 50);
    if (t >= 50) begin
      n_fail++;
      print_verdict();
    end
    rd = rdata; // taken at the edge where waitrequest is seen low
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(negedge mclk); // flags land at the write edge, settled by mid-cycle
  endtask : acc
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    wd = 32'h0000_0000;
    n_fail = 0;
    compares = 0;
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    acc(1, `PCQ_OFS_CTRL, 32'h0000_0100);
    chk(em, 1'b1);
    acc(0, `PCQ_OFS_LEVEL, 0);
    chk(rd, 32'h0000_0010);
    acc(1, `PCQ_OFS_OFFSET, 32'h0000_000A);
    acc(1, `PCQ_OFS_CAPACITY, 32'h0000_0004);
    acc(1, `PCQ_OFS_LEVEL, 32'h0000_0002);
    // fifth push must bounce off a full queue
    for (i = 1; i <= 5; i++) begin
      acc(1, `PCQ_OFS_PUSH, 32'h0000_1000 * i);
      chk(old, 32'h0000_1000);
      chk(trg, 32'h0000_100A);
      chk(hw, i >= 2);
      chk(ov, i >= 4);
    end
    acc(0, `PCQ_OFS_STATUS, 0);
    chk(rd[11:8], 4'h4);
    for (i = 2; i <= 5; i++) begin
      acc(1, `PCQ_OFS_CTRL, 32'h0000_0200);
      chk(old, (i < 5) ? 32'h0000_1000 * i : 32'h0);
      chk(em, i == 5);
      chk(hw, i <= 3);
      chk(ov, 1'b0);
    end
    $display("fill and drain done");
    acc(1, `PCQ_OFS_PUSH, 32'h0000_0050);
    acc(1, `PCQ_OFS_PUSH, 32'h0000_0060);
    acc(1, `PCQ_OFS_OFFSET, 32'h0000_0020);
    chk(trg, 32'h0000_005A);
    acc(1, `PCQ_OFS_CTRL, 32'h0000_0200);
    chk(trg, 32'h0000_0080);
    acc(1, `PCQ_OFS_CTRL, 32'h0000_0100);
    chk(em, 1'b1);
    $display("offset and flush done");
    for (i = 0; i < 3; i++) begin
      acc(1, `PCQ_OFS_CTRL, 32'h0000_0001 | (i << 1));
      v = pos[i] + 32'h0000_0020;
      acc(1, `PCQ_OFS_PUSH, v);
      chk(trg, v + 32'h0000_0020);
      for (k = 0; k < 200 && mt !== 1'b1; k++) @(negedge mclk);
      chk(mt, 1'b1);
      chk(pos[i], trg + 32'h0000_0001);
      acc(1, `PCQ_OFS_CTRL, 32'h0000_0201 | (i << 1));
      chk(mt, 1'b0);
    end
    acc(1, `PCQ_OFS_CTRL, 32'h0000_0000);
    acc(1, `PCQ_OFS_PUSH, pf + 32'h0000_0010);
    repeat (100) @(negedge mclk);
    chk(mt, 1'b0);
    $display("compare tests done");
    print_verdict();
  end
endmodule : tb_position_compare_queue
